// ===== verilog/mms_monitor.sv
// min/max result tracking, three-phase sag detection and energy unit registers
// Notes on behaviour
// RL1 - energy unit is 24-bit integer word plus 24-bit fraction word, lsb 2^-24.
// RL2 - eight output register pairs track min and max of selected low-rate results.
// RL3 - host picks each tracked result by writing its word address into a slot.
// RL4 - a slot holding zero does no tracking at all.
// RL5 - slot defaults come from nonvolatile storage after initialisation.
// RL6 - tracked results are volatile and cleared by reset or power-down.
// RL7 - tracking-clear command bit clears every tracked min and max.
// RL8 - min n holds smallest, max n largest value seen at slot n address.
// RL9 - phases A, B and C each have their own sag detector.
// RL10 - indicator sums squared sample minus squared threshold over the window.
// RL11 - host should make the window a whole number of line periods, at least half.
// RL12 - a negative indicator sets that phase's sag flag.
// RL13 - a flag enabled in the alarm mask drives the alarm pin low.
// RL14 - sticky flags and their alarm hold until host clear or reset.
// RL15 - non-sticky flags and alarm release once the indicator is no longer negative.
// RL16 - host programs threshold as rms value; device squares it.
// RL17 - host keeps the energy unit integer part nonzero.
// RL18 - min and max compare once per low-rate result as it arrives.
// RL19 - indicator is judged at each window end, then the sum restarts.
`timescale 1ns/1ps
module mms_monitor
    import mms_pkg::*;
(
    // clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  resetn_i,
    // nonvolatile slot defaults, taken after reset release
    input  wire logic [mms_pkg::SLOT_N-1:0][mms_pkg::SLOT_W-1:0] nv_slot_default_i,
    // register port from the serial host interface, word addressed
    input  wire logic [mms_pkg::RADDR_W-1:0]           reg_addr_i,
    input  wire logic [mms_pkg::DATA_W-1:0]            reg_wdata_i,
    input  wire logic                                  reg_we_i,
    input  wire logic                                  reg_rd_i,
    output logic      [mms_pkg::DATA_W-1:0]            reg_rdata_o,
    // low-rate results as they are published
    input  wire logic                                  result_valid_i,
    input  wire logic [mms_pkg::SLOT_W-1:0]            result_addr_i,
    input  wire logic [mms_pkg::DATA_W-1:0]            result_data_i,
    // high-rate phase samples
    input  wire logic                                  sample_valid_i,
    input  wire logic [mms_pkg::PHASE_N-1:0][mms_pkg::DATA_W-1:0] sample_i,
    // status and alarm
    output logic      [mms_pkg::PHASE_N-1:0]           phase_sag_flag_o,
    output logic                                       alarm_output_pin_n_o
);
    import mms_pkg::*;

    typedef struct packed {
        logic                                   init_done;
        logic [DATA_W-1:0]                      eu_int;
        logic [DATA_W-1:0]                      eu_frac;
        logic [SLOT_N-1:0][SLOT_W-1:0]          slot;
        logic [SLOT_N-1:0]                      seen;
        logic [SLOT_N-1:0][DATA_W-1:0]          mn;
        logic [SLOT_N-1:0][DATA_W-1:0]          mx;
        logic [DATA_W-1:0]                      thr;
        logic [2*DATA_W-1:0]                    thr_sq;
        logic [WIN_W-1:0]                       win;
        logic [PHASE_N-1:0]                     flag;
        logic [PHASE_N-1:0]                     sticky;
        logic [PHASE_N-1:0]                     mask;
        logic                                   alarm_n;
        logic [DATA_W-1:0]                      rdata;
    } mms_state_s;

    mms_state_s st_reg;
    mms_state_s st_next;
    logic       rst_meta_reg;
    logic       rst_n_reg;
    logic [PHASE_N-1:0] ph_done;
    logic [PHASE_N-1:0] ph_neg;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    function automatic logic [DATA_W-1:0] read_word(input mms_state_s s,
                                                    input logic [RADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        case (a)
            ADR_EU_INT:  v = s.eu_int;
            ADR_EU_FRAC: v = s.eu_frac;
            ADR_SAG_THR: v = s.thr;
            ADR_SAG_WIN: v = {8'h00, s.win};
            ADR_STATUS:  v = {21'h000000, s.flag};
            ADR_STICKY:  v = {21'h000000, s.sticky};
            ADR_MASK:    v = {21'h000000, s.mask};
            default: begin
                if (a[7:3] == ADR_SLOT0[7:3]) begin
                    v = {16'h0000, s.slot[a[2:0]]};
                end else if (a[7:3] == ADR_MIN0[7:3]) begin
                    v = s.mn[a[2:0]]; // RL2
                end else if (a[7:3] == ADR_MAX0[7:3]) begin
                    v = s.mx[a[2:0]]; // RL2
                end
            end
        endcase
        return v;
    endfunction : read_word

    always_comb begin
        logic [PHASE_N-1:0] clr;
        clr = '0;
        st_next = st_reg;
        st_next.thr_sq = 48'(st_reg.thr * st_reg.thr); // RL16
        // nonvolatile defaults replace the slots once, just after release
        if (!st_reg.init_done) begin
            st_next.init_done = 1'b1;
            st_next.slot = nv_slot_default_i; // RL5
        end
        if (reg_rd_i) begin
            st_next.rdata = read_word(st_reg, reg_addr_i);
        end
        if (reg_we_i) begin
            case (reg_addr_i)
                ADR_EU_INT:  st_next.eu_int = reg_wdata_i; // RL1
                ADR_EU_FRAC: st_next.eu_frac = reg_wdata_i; // RL1
                ADR_SAG_THR: st_next.thr = reg_wdata_i;
                ADR_SAG_WIN: st_next.win = reg_wdata_i[WIN_W-1:0];
                ADR_STICKY:  st_next.sticky = reg_wdata_i[PHASE_N-1:0];
                ADR_MASK:    st_next.mask = reg_wdata_i[PHASE_N-1:0];
                ADR_CLEAR:   clr = reg_wdata_i[PHASE_N-1:0];
                ADR_COMMAND: begin
                    if (reg_wdata_i[CMD_TRK_CLR_BIT]) begin
                        st_next.seen = '0; // RL7
                        st_next.mn = '0;
                        st_next.mx = '0;
                    end
                end
                default: begin
                    if (reg_addr_i[7:3] == ADR_SLOT0[7:3]) begin
                        st_next.slot[reg_addr_i[2:0]] = reg_wdata_i[SLOT_W-1:0]; // RL3
                    end
                end
            endcase
        end
        // a result arriving with the clear command starts the fresh history
        if (result_valid_i) begin
            for (int i = 0; i < SLOT_N; i++) begin
                if (st_reg.slot[i] != '0 && st_reg.slot[i] == result_addr_i) begin // RL4
                    if (!st_next.seen[i]
                        || $signed(result_data_i) < $signed(st_next.mn[i])) begin
                        st_next.mn[i] = result_data_i; // RL8
                    end
                    if (!st_next.seen[i]
                        || $signed(result_data_i) > $signed(st_next.mx[i])) begin
                        st_next.mx[i] = result_data_i; // RL8
                    end
                    st_next.seen[i] = 1'b1; // RL18
                end
            end
        end
        for (int p = 0; p < PHASE_N; p++) begin
            if (clr[p]) begin
                st_next.flag[p] = 1'b0; // RL14
            end
            if (ph_done[p]) begin
                if (ph_neg[p]) begin
                    st_next.flag[p] = 1'b1; // RL12
                end else if (!st_reg.sticky[p]) begin
                    st_next.flag[p] = 1'b0; // RL15
                end
            end
        end
        st_next.alarm_n = ~|(st_next.flag & st_reg.mask); // RL13
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            st_reg <= '0; // RL6
            st_reg.eu_int <= RST_EU_INT;
            st_reg.eu_frac <= RST_EU_FRAC;
            st_reg.thr <= RST_SAG_THR;
            st_reg.win <= RST_SAG_WIN;
            st_reg.sticky <= RST_STICKY;
            st_reg.mask <= RST_MASK;
            st_reg.alarm_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // one independent accumulator per phase
    for (genvar g = 0; g < PHASE_N; g++) begin : g_phase
        mms_phase_if ph_if ();
        assign ph_if.sample_valid = sample_valid_i;
        assign ph_if.sample = sample_i[g];
        assign ph_if.thr_sq = st_reg.thr_sq;
        assign ph_if.window = st_reg.win;
        assign ph_done[g] = ph_if.done;
        assign ph_neg[g] = ph_if.negative;
        mms_sag_phase u_sag ( // RL9
            .clk_i   (clk_i),
            .rst_n_i (rst_n_reg),
            .ph      (ph_if.phase)
        );
    end

    assign reg_rdata_o = st_reg.rdata;
    assign phase_sag_flag_o = st_reg.flag;
    assign alarm_output_pin_n_o = st_reg.alarm_n;
endmodule : mms_monitor

// ===== verilog/mms_pkg.sv
// package: register map, field layout and reset values of the min/max and sag monitor
package mms_pkg;
    localparam int  DATA_W = 24;
    localparam int  RADDR_W = 8;
    localparam int  SLOT_N = 8;
    localparam int  SLOT_W = 8;
    localparam int  WIN_W = 16;
    localparam int  ACC_W = 64;
    localparam int  PHASE_N = 3;

    // host word addresses
    localparam logic [RADDR_W-1:0] ADR_EU_INT = 8'h00;
    localparam logic [RADDR_W-1:0] ADR_EU_FRAC = 8'h01;
    localparam logic [RADDR_W-1:0] ADR_COMMAND = 8'h02;
    localparam logic [RADDR_W-1:0] ADR_SAG_THR = 8'h03;
    localparam logic [RADDR_W-1:0] ADR_SAG_WIN = 8'h04;
    localparam logic [RADDR_W-1:0] ADR_STATUS = 8'h05;
    localparam logic [RADDR_W-1:0] ADR_STICKY = 8'h06;
    localparam logic [RADDR_W-1:0] ADR_MASK = 8'h07;
    localparam logic [RADDR_W-1:0] ADR_CLEAR = 8'h08;
    localparam logic [RADDR_W-1:0] ADR_SLOT0 = 8'h10;
    localparam logic [RADDR_W-1:0] ADR_MIN0 = 8'h20;
    localparam logic [RADDR_W-1:0] ADR_MAX0 = 8'h28;

    // field positions
    localparam int  CMD_TRK_CLR_BIT = 0;
    localparam int  SAG_A_BIT = 0;

    // reset values
    localparam logic [DATA_W-1:0] RST_EU_INT = 24'h000001;
    localparam logic [DATA_W-1:0] RST_EU_FRAC = 24'h000000;
    localparam logic [DATA_W-1:0] RST_SAG_THR = 24'h000000;
    localparam logic [WIN_W-1:0]  RST_SAG_WIN = 16'h001a;
    localparam logic [PHASE_N-1:0] RST_STICKY = 3'h0;
    localparam logic [PHASE_N-1:0] RST_MASK = 3'h0;
endpackage : mms_pkg

// ===== verilog/mms_phase_if.sv
// carrier between the monitor top and one per-phase sag accumulator
`timescale 1ns/1ps
interface mms_phase_if;
    import mms_pkg::*;
    logic                   sample_valid;
    logic [DATA_W-1:0]      sample;
    logic [2*DATA_W-1:0]    thr_sq;
    logic [WIN_W-1:0]       window;
    logic                   done;
    logic                   negative;

    modport top   (output sample_valid, sample, thr_sq, window, input done, negative);
    modport phase (input sample_valid, sample, thr_sq, window, output done, negative);
endinterface : mms_phase_if

// ===== verilog/mms_sag_phase.sv
// windowed sum of squared sample minus squared threshold for one phase
`timescale 1ns/1ps
module mms_sag_phase
    import mms_pkg::*;
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    // phase link
    mms_phase_if.phase     ph
);
    typedef struct packed {
        logic [WIN_W-1:0]         count;
        logic signed [ACC_W-1:0]  acc;
        logic                     done;
        logic                     negative;
    } mms_sag_s;

    mms_sag_s r_reg;
    mms_sag_s r_next;

    always_comb begin
        logic signed [ACC_W-1:0] term;
        logic signed [ACC_W-1:0] sum;
        term = '0;
        sum = '0;
        r_next = r_reg;
        r_next.done = 1'b0;
        term = $signed({16'h0000, 48'($signed(ph.sample) * $signed(ph.sample))})
             - $signed({16'h0000, ph.thr_sq}); // RL10
        sum = r_reg.acc + term;
        if (ph.sample_valid) begin
            // a window of zero is taken as one sample so the detector never stalls
            if ((r_reg.count + 16'h0001) >= ph.window) begin
                r_next.done = 1'b1; // RL19
                r_next.negative = sum[ACC_W-1];
                r_next.acc = '0;
                r_next.count = '0;
            end else begin
                r_next.acc = sum;
                r_next.count = r_reg.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign ph.done = r_reg.done;
    assign ph.negative = r_reg.negative;
endmodule : mms_sag_phase

// ===== sim/mms_monitor_properties.sv
// checker: port-level properties of the min/max and sag monitor
`timescale 1ns/1ps
module mms_monitor_props
    import mms_pkg::*;
(
    // clock and reset
    input wire logic                clk_i,
    input wire logic                resetn_i,
    // register port
    input wire logic [RADDR_W-1:0]  reg_addr_i,
    input wire logic                reg_we_i,
    input wire logic                reg_rd_i,
    input wire logic [DATA_W-1:0]   reg_rdata_o,
    // samples, status and alarm
    input wire logic                sample_valid_i,
    input wire logic [PHASE_N-1:0]  phase_sag_flag_o,
    input wire logic                alarm_output_pin_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic clr_wr;
    logic rst_seen = 1'b0;
    assign clr_wr = reg_we_i && reg_addr_i == ADR_CLEAR;

    // outputs are unknown until the first edge in reset has run the reset flops
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_seen <= 1'b1;
        end
    end

    chk_reset_quiet: assert property (disable iff (1'b0) !resetn_i && rst_seen |->
        alarm_output_pin_n_o && phase_sag_flag_o == '0) else $error("outputs active in reset");
    chk_alarm_has_flag: assert property (!alarm_output_pin_n_o |-> phase_sag_flag_o != '0)
        else $error("alarm low with no flag");
    chk_flag_set_window: assert property ((phase_sag_flag_o & ~$past(phase_sag_flag_o)) != '0
        |-> $past(sample_valid_i, 2) || $past(sample_valid_i, 3)) else $error("flag set off window");
    chk_flag_fall_cause: assert property ((~phase_sag_flag_o & $past(phase_sag_flag_o)) != '0
        |-> $past(sample_valid_i, 2) || $past(sample_valid_i, 3) || $past(clr_wr)
        || $past(clr_wr, 2)) else $error("flag cleared without cause");
    chk_alarm_follow: assert property ($changed(alarm_output_pin_n_o) |->
        $changed(phase_sag_flag_o) || $past(reg_we_i) || $past(reg_we_i, 2))
        else $error("alarm moved alone");
    chk_status_read: assert property (reg_rd_i && reg_addr_i == ADR_STATUS |=>
        reg_rdata_o[PHASE_N-1:0] == $past(phase_sag_flag_o)) else $error("status read wrong");
    chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h3f |=> reg_rdata_o == '0)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data moved without read");

    cov_flag_rise: cover property ($rose(phase_sag_flag_o[0]));
    cov_alarm_low: cover property ($fell(alarm_output_pin_n_o));
    cov_clear_wr: cover property (clr_wr);
endmodule : mms_monitor_props

bind mms_monitor mms_monitor_props u_props (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
    .phase_sag_flag_o(phase_sag_flag_o), .alarm_output_pin_n_o(alarm_output_pin_n_o));

// ===== sim/mms_host_model.sv
// host side model: drives the word-addressed register port
`timescale 1ns/1ps
module mms_host_model
    import mms_pkg::*;
(
    input  wire logic           clk_i,
    output logic [RADDR_W-1:0]  reg_addr_o,
    output logic [DATA_W-1:0]   reg_wdata_o,
    output logic                reg_we_o,
    output logic                reg_rd_o
);
    initial begin
        reg_addr_o  = '0;
        reg_wdata_o = '0;
        reg_we_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    // one strobe cycle per access, so back-to-back calls never touch a strobe twice per edge
    task automatic wr(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (a == ADR_EU_INT && d == '0) d = 24'h000001;
        if (a == ADR_SAG_WIN && d == '0) d = 24'h000001;
        @(posedge clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_we_o    <= 1'b1;
        @(posedge clk_i);
        reg_we_o    <= 1'b0;
        reg_wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [RADDR_W-1:0] a);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
    endtask : rd
endmodule : mms_host_model

// ===== sim/tb_minmax_tracking_sag_detect.sv
// testbench: min/max tracking and sag detection at the monitor ports
`timescale 1ns/1ps
module tb_minmax_tracking_sag_detect;
    import mms_pkg::*;
    logic                           clk = 1'b0, resetn = 1'b0, rd_seen = 1'b0;
    logic                           we, rd, alarm_n, res_v = 1'b0, smp_v = 1'b0;
    logic [SLOT_N-1:0][SLOT_W-1:0]  nv_slot = {48'h777675747355, 16'h0040};
    logic [RADDR_W-1:0]             addr;
    logic [DATA_W-1:0]              wdata, rdata, res_d = '0;
    logic [SLOT_W-1:0]              res_a = '0;
    logic [PHASE_N-1:0][DATA_W-1:0] smp = '0;
    logic [PHASE_N-1:0]             flags;
    logic [DATA_W+1:0]              notes[$], n;
    logic signed [DATA_W-1:0]       mn[3], mx[3], d;
    int                             num_errors = 0, checks_done = 0, seed = 25, j;

    mms_host_model u_host (.clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_we_o(we), .reg_rd_o(rd));
    mms_monitor DUT (.clk_i(clk), .resetn_i(resetn), .nv_slot_default_i(nv_slot),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .result_valid_i(res_v), .result_addr_i(res_a),
        .result_data_i(res_d), .sample_valid_i(smp_v), .sample_i(smp),
        .phase_sag_flag_o(flags), .alarm_output_pin_n_o(alarm_n));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // note top bits: check alarm, expected alarm level
    always @(posedge clk) begin
        if (rd_seen) begin
            n = notes.pop_front();
            checks_done++;
            if (rdata !== n[DATA_W-1:0]
                || (n[DATA_W+1] && (alarm_n !== n[DATA_W] || flags !== n[PHASE_N-1:0]))) begin
                num_errors++;
                $display("Error read/alarm/flags expected %h seen %h %b %b", n, rdata, alarm_n,
                         flags);
            end
        end
        rd_seen <= rd;
    end

    task automatic rd_chk(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                          input logic [1:0] al = 2'b00);
        u_host.rd(a);
        notes.push_back({al, e});
    endtask : rd_chk
    task automatic res(input logic [SLOT_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        res_v <= 1'b1;
        res_a <= a;
        res_d <= v;
        @(posedge clk);
        res_v <= 1'b0;
    endtask : res
    task automatic win(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        repeat (2) begin
            @(posedge clk);
            smp_v <= 1'b1;
            smp   <= {24'd1000, b, a};
            @(posedge clk);
            smp_v <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask : win
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(ADR_EU_INT, RST_EU_INT);
        rd_chk(ADR_EU_FRAC, RST_EU_FRAC);
        rd_chk(ADR_SAG_WIN, {8'h00, RST_SAG_WIN});
        rd_chk(ADR_SLOT0, 24'h000040);
        rd_chk(8'h3f, '0);
        u_host.wr(ADR_EU_INT, 24'h000114);
        u_host.wr(ADR_EU_FRAC, 24'h5bf722);
        rd_chk(ADR_EU_INT, 24'h000114);
        rd_chk(ADR_EU_FRAC, 24'h5bf722);
        u_host.wr(ADR_SLOT0 + 8'h02, 24'h000041);
        rd_chk(ADR_SLOT0 + 8'h02, 24'h000041);
        for (int k = 0; k < 30; k++) begin
            d = 24'($random(seed));
            j = k % 3;
            res(j == 0 ? 8'h40 : (j == 1 ? 8'h00 : 8'h41), d);
            if (k < 3 || d < mn[j]) mn[j] = d;
            if (k < 3 || d > mx[j]) mx[j] = d;
        end
        mn[1] = '0;
        mx[1] = '0;
        for (int k = 0; k < 3; k++) begin
            rd_chk(ADR_MIN0 + 8'(k), mn[k]);
            rd_chk(ADR_MAX0 + 8'(k), mx[k]);
        end
        u_host.wr(ADR_COMMAND, 24'h000001);
        for (int k = 0; k < 3; k++) begin
            rd_chk(ADR_MIN0 + 8'(k), '0);
            rd_chk(ADR_MAX0 + 8'(k), '0);
        end
        u_host.wr(ADR_SAG_WIN, 24'h000002);
        u_host.wr(ADR_SAG_THR, 24'd100);
        u_host.wr(ADR_MASK, 24'h000001);
        win(24'd10, 24'd1000);
        rd_chk(ADR_STATUS, 24'h000001, 2'b10);
        win(24'd1000, 24'd1000);
        rd_chk(ADR_STATUS, 24'h000000, 2'b11);
        u_host.wr(ADR_STICKY, 24'h000001);
        win(24'd10, 24'd1000);
        win(24'd1000, 24'd1000);
        rd_chk(ADR_STATUS, 24'h000001, 2'b10);
        u_host.wr(ADR_CLEAR, 24'h000001);
        rd_chk(ADR_STATUS, 24'h000000, 2'b11);
        win(24'd1000, 24'd10);
        rd_chk(ADR_STATUS, 24'h000002, 2'b11);
        res(8'h40, 24'h000123);
        rd_chk(ADR_MIN0, 24'h000123);
        rd_chk(ADR_MAX0, 24'h000123);
        // second reset in mid-run: tracked results, flags and registers return to reset
        repeat (2) @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(ADR_MIN0, '0);
        rd_chk(ADR_MAX0, '0);
        rd_chk(ADR_EU_INT, RST_EU_INT);
        rd_chk(ADR_SLOT0, 24'h000040);
        rd_chk(ADR_STATUS, 24'h000000, 2'b11);
        repeat (3) @(posedge clk);
        report_and_stop;
    end
endmodule : tb_minmax_tracking_sag_detect
